// [hw/mmfeat_defs.svh]
`ifndef MMFEAT_DEFS_SVH
`define MMFEAT_DEFS_SVH
// Contract
// - Two fixed 64-bit read-only feature words.
// - Level 0 reads trap, to 2 or 1.
// - Level 1 reads trap to 2 under group-3 bit.
// - Levels 2 and 3 always read the value.
// - Select by op0, op1, CRn, CRm; op2 picks word.
// - Reserved field ranges read as zero.
// - First word counter virtualization field reports two.
// - First word fine trap field reports one.
// - First word exception sync field reports zero.
// - Stage-2 granule fields all report two.
// - Stage-1 granules report zero, zero, one.
// - Secure split field reports one.
// - Mixed endian field reports one.
// - Space identifier width field reports two.
// - Physical range field reports two.
// - Second word branch history guard reports one.
// - Float, hyp config, translation sync report one.
// - Delayed wait trap field reports zero.
// - Exec-never split and speculative error report one.
// - Privileged access never field reports three.
// - Hier disable two; ordering, host one.
// - VM id width two; flag update two.

`define SEL_OP0             2'h3
`define SEL_OP1             3'h0
`define SEL_CRN             4'h0
`define SEL_CRM             4'h7
`define SEL_OP2_FIRST       3'h0
`define SEL_OP2_SECOND      3'h1
`define TRAP_SYNDROME       6'h18
`define WORD_RESET          64'h0000000000000000

`define COUNTER_VIRT_CODE       4'h2
`define FINE_TRAP_CODE          4'h1
`define EXCEPTION_SYNC_CODE     4'h0
`define STAGE2_GRANULE_CODE     4'h2
`define GRANULE_SMALL_CODE      4'h0
`define GRANULE_LARGE_CODE      4'h0
`define GRANULE_MID_CODE        4'h1
`define SECURE_SPLIT_CODE       4'h1
`define MIXED_ENDIAN_CODE       4'h1
`define SPACE_ID_WIDTH_CODE     4'h2
`define PHYS_RANGE_CODE         4'h2

`define BRANCH_HISTORY_GUARD_CODE 4'h1
`define WALK_CACHE_CODE         4'h1
`define ALT_FLOAT_CTRL_CODE     4'h1
`define EXT_HYP_CONFIG_CODE     4'h1
`define TRANSLATION_SYNC_CODE   4'h1
`define DELAYED_WAIT_TRAP_CODE  4'h0
`define EXEC_NEVER_SPLIT_CODE   4'h1
`define SPEC_ERROR_CODE         4'h1
`define PRIV_ACCESS_NEVER_CODE  4'h3
`define ORDERING_REGION_CODE    4'h1
`define HIER_PERM_DISABLE_CODE  4'h2
`define HOST_EXT_CODE           4'h1
`define VM_ID_WIDTH_CODE        4'h2
`define HW_FLAG_UPDATE_CODE     4'h2

`endif

// [hw/mmfeat_pkg.sv]
package mmfeat_pkg;

  typedef enum logic [1:0] {
    LEVEL0 = 2'h0,
    LEVEL1 = 2'h1,
    LEVEL2 = 2'h2,
    LEVEL3 = 2'h3
  } exc_level_t;

  typedef enum logic [2:0] {
    ACC_RETURN   = 3'h0,
    ACC_TRAP_LOW = 3'h1,
    ACC_TRAP_HYP = 3'h2,
    ACC_UNDEF    = 3'h3,
    ACC_MISS     = 3'h4
  } access_t;

  typedef struct packed {
    logic       write;
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    exc_level_t current_level;
  } sysreg_req_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic        undef;
    logic        trap;
    exc_level_t  trap_level;
    logic [5:0]  syndrome;
    logic [63:0] data;
  } sysreg_resp_t;

endpackage

// [hw/id_value_rom.sv]
`timescale 1ns/10ps
`include "mmfeat_defs.svh"

module id_value_rom #(
  parameter int WIDTH = 64
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             rd_en_i,
  input  wire logic             rd_sel_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  // The words are constants with no write port at all.
  localparam logic [WIDTH-1:0] FIRST_WORD = WIDTH'({
    `COUNTER_VIRT_CODE,
    `FINE_TRAP_CODE,
    8'h00,
    `EXCEPTION_SYNC_CODE,
    {3{`STAGE2_GRANULE_CODE}},
    `GRANULE_SMALL_CODE, `GRANULE_LARGE_CODE,
    `GRANULE_MID_CODE,
    4'h0,
    `SECURE_SPLIT_CODE,
    `MIXED_ENDIAN_CODE,
    `SPACE_ID_WIDTH_CODE,
    `PHYS_RANGE_CODE});

  localparam logic [WIDTH-1:0] SECOND_WORD = WIDTH'({
    `BRANCH_HISTORY_GUARD_CODE,
    8'h00,
    `WALK_CACHE_CODE,
    `ALT_FLOAT_CTRL_CODE, `EXT_HYP_CONFIG_CODE,
    `TRANSLATION_SYNC_CODE,
    `DELAYED_WAIT_TRAP_CODE,
    `EXEC_NEVER_SPLIT_CODE, `SPEC_ERROR_CODE,
    `PRIV_ACCESS_NEVER_CODE,
    `ORDERING_REGION_CODE,
    `HIER_PERM_DISABLE_CODE, `HOST_EXT_CODE,
    `VM_ID_WIDTH_CODE, `HW_FLAG_UPDATE_CODE});

  logic [WIDTH-1:0] rd_data_ff;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_ff <= WIDTH'(`WORD_RESET);
    end else if (rd_en_i) begin
      rd_data_ff <= rd_sel_i ? SECOND_WORD : FIRST_WORD;
    end
  end

  assign rd_data_o = rd_data_ff;

endmodule

// [hw/level_access_check.sv]
`timescale 1ns/10ps

module level_access_check (
  input  wire mmfeat_pkg::exc_level_t current_level_i,
  input  wire logic                   el2_enabled_i,
  input  wire logic                   general_trap_bit_i,
  input  wire logic                   id_group3_trap_bit_i,
  output mmfeat_pkg::access_t         outcome_o
);

  always_comb begin
    unique case (current_level_i)
      mmfeat_pkg::LEVEL0: begin
        if (el2_enabled_i && general_trap_bit_i) begin
          outcome_o = mmfeat_pkg::ACC_TRAP_HYP;
        end else begin
          outcome_o = mmfeat_pkg::ACC_TRAP_LOW;
        end
      end
      mmfeat_pkg::LEVEL1: begin
        if (el2_enabled_i && id_group3_trap_bit_i) begin
          outcome_o = mmfeat_pkg::ACC_TRAP_HYP;
        end else begin
          outcome_o = mmfeat_pkg::ACC_RETURN;
        end
      end
      mmfeat_pkg::LEVEL2,
      mmfeat_pkg::LEVEL3: begin
        outcome_o = mmfeat_pkg::ACC_RETURN;
      end
    endcase
  end

endmodule

// [hw/memory_model_feature_id_regs.sv]
`timescale 1ns/10ps
`include "mmfeat_defs.svh"

module memory_model_feature_id_regs (
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    req_valid_i,
  input  wire mmfeat_pkg::sysreg_req_t req_i,
  input  wire logic                    el2_enabled_i,
  input  wire logic                    general_trap_bit_i,
  input  wire logic                    id_group3_trap_bit_i,
  output mmfeat_pkg::sysreg_resp_t     resp_o
);

  // Selects one of the two words; bit 1 flags a match, bit 0 the word.
  function automatic logic [1:0] decode_sel(
    input mmfeat_pkg::sysreg_req_t r
  );
    logic common;
    common = (r.op0 == `SEL_OP0) && (r.op1 == `SEL_OP1) &&
             (r.crn == `SEL_CRN) && (r.crm == `SEL_CRM);
    if (common && (r.op2 == `SEL_OP2_FIRST)) begin
      decode_sel = 2'h2;
    end else if (common && (r.op2 == `SEL_OP2_SECOND)) begin
      decode_sel = 2'h3;
    end else begin
      decode_sel = 2'h0;
    end
  endfunction

  logic [1:0]               req_sel;
  logic                     req_hit;
  mmfeat_pkg::access_t      chk_outcome;
  mmfeat_pkg::access_t      nxt_outcome;
  logic [63:0]              rom_data;

  logic                     s1_valid_ff;
  mmfeat_pkg::access_t      s1_outcome_ff;
  mmfeat_pkg::sysreg_resp_t resp_ff;
  mmfeat_pkg::sysreg_resp_t nxt_resp;

  assign req_sel = decode_sel(req_i);
  assign req_hit = req_sel[1];

  level_access_check u_check (
    .current_level_i      (req_i.current_level),
    .el2_enabled_i        (el2_enabled_i),
    .general_trap_bit_i   (general_trap_bit_i),
    .id_group3_trap_bit_i (id_group3_trap_bit_i),
    .outcome_o            (chk_outcome)
  );

  // A write to an identification word is refused as undefined.
  always_comb begin
    if (!req_hit) begin
      nxt_outcome = mmfeat_pkg::ACC_MISS;
    end else if (req_i.write) begin
      nxt_outcome = mmfeat_pkg::ACC_UNDEF;
    end else begin
      nxt_outcome = chk_outcome;
    end
  end

  // The word is fetched even for a trapped read; the answer stage masks it.
  id_value_rom #(
    .WIDTH (64)
  ) u_rom (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .rd_en_i   (req_valid_i && req_hit),
    .rd_sel_i  (req_sel[0]),
    .rd_data_o (rom_data)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_valid_ff <= 1'b0;
    end else begin
      s1_valid_ff <= req_valid_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_outcome_ff <= mmfeat_pkg::ACC_MISS;
    end else if (req_valid_i) begin
      s1_outcome_ff <= nxt_outcome;
    end
  end

  always_comb begin
    nxt_resp            = '0;
    nxt_resp.valid      = s1_valid_ff;
    nxt_resp.trap_level = mmfeat_pkg::LEVEL0;
    if (s1_valid_ff) begin
      unique case (s1_outcome_ff)
        mmfeat_pkg::ACC_RETURN: begin
          nxt_resp.hit  = 1'b1;
          nxt_resp.data = rom_data;
        end
        mmfeat_pkg::ACC_TRAP_LOW: begin
          nxt_resp.hit        = 1'b1;
          nxt_resp.trap       = 1'b1;
          nxt_resp.trap_level = mmfeat_pkg::LEVEL1;
          nxt_resp.syndrome   = `TRAP_SYNDROME;
        end
        mmfeat_pkg::ACC_TRAP_HYP: begin
          nxt_resp.hit        = 1'b1;
          nxt_resp.trap       = 1'b1;
          nxt_resp.trap_level = mmfeat_pkg::LEVEL2;
          nxt_resp.syndrome   = `TRAP_SYNDROME;
        end
        mmfeat_pkg::ACC_UNDEF: begin
          nxt_resp.hit   = 1'b1;
          nxt_resp.undef = 1'b1;
        end
        mmfeat_pkg::ACC_MISS: begin
          nxt_resp.hit = 1'b0;
        end
        default: begin
          nxt_resp.hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_ff <= '0;
    end else begin
      resp_ff <= nxt_resp;
    end
  end

  assign resp_o = resp_ff;

  // Helper state that only the checks below read.
  logic sel1_ff;
  logic sel2_ff;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel1_ff <= 1'b0;
      sel2_ff <= 1'b0;
    end else begin
      sel1_ff <= req_sel[0];
      sel2_ff <= sel1_ff;
    end
  end

  logic rd_req;
  logic ret_first;
  logic ret_second;

  assign rd_req     = req_valid_i && req_hit && !req_i.write;
  assign ret_first  = resp_ff.valid && resp_ff.hit && !resp_ff.trap &&
                      !resp_ff.undef && !sel2_ff;
  assign ret_second = resp_ff.valid && resp_ff.hit && !resp_ff.trap &&
                      !resp_ff.undef && sel2_ff;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_answer_timing;
    req_valid_i |-> ##2 resp_ff.valid;
  endproperty
  a_answer_timing: assert property (p_answer_timing)
    else $error("request not answered two cycles later");

  property p_no_spurious;
    !req_valid_i |-> ##2 !resp_ff.valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("answer without a request");

  property p_low_hyp_trap;
    rd_req && (req_i.current_level == mmfeat_pkg::LEVEL0) &&
    el2_enabled_i && general_trap_bit_i
    |-> ##2 resp_ff.trap && (resp_ff.trap_level == mmfeat_pkg::LEVEL2)
        && (resp_ff.syndrome == `TRAP_SYNDROME) && (resp_ff.data == '0);
  endproperty
  a_low_hyp_trap: assert property (p_low_hyp_trap)
    else $error("level 0 read did not trap to level 2");

  property p_low_trap;
    rd_req && (req_i.current_level == mmfeat_pkg::LEVEL0) &&
    !(el2_enabled_i && general_trap_bit_i)
    |-> ##2 resp_ff.trap && (resp_ff.trap_level == mmfeat_pkg::LEVEL1)
        && (resp_ff.syndrome == `TRAP_SYNDROME) && (resp_ff.data == '0);
  endproperty
  a_low_trap: assert property (p_low_trap)
    else $error("level 0 read did not trap to level 1");

  property p_kernel_hyp_trap;
    rd_req && (req_i.current_level == mmfeat_pkg::LEVEL1) &&
    el2_enabled_i && id_group3_trap_bit_i
    |-> ##2 resp_ff.trap && (resp_ff.trap_level == mmfeat_pkg::LEVEL2)
        && (resp_ff.syndrome == `TRAP_SYNDROME);
  endproperty
  a_kernel_hyp_trap: assert property (p_kernel_hyp_trap)
    else $error("level 1 read did not trap to level 2");

  property p_kernel_return;
    rd_req && (req_i.current_level == mmfeat_pkg::LEVEL1) &&
    !(el2_enabled_i && id_group3_trap_bit_i)
    |-> ##2 !resp_ff.trap && resp_ff.hit && (resp_ff.data != '0);
  endproperty
  a_kernel_return: assert property (p_kernel_return)
    else $error("level 1 read did not return the word");

  property p_high_return;
    rd_req && req_i.current_level[1]
    |-> ##2 !resp_ff.trap && (resp_ff.syndrome == '0)
        && (resp_ff.data != '0);
  endproperty
  a_high_return: assert property (p_high_return)
    else $error("level 2 or 3 read was trapped");

  property p_same_checks;
    rd_req && req_sel[0]
    |-> ##2 (resp_ff.trap ==
             (($past(req_i.current_level, 2) == mmfeat_pkg::LEVEL0) ||
              (($past(req_i.current_level, 2) == mmfeat_pkg::LEVEL1) &&
               $past(el2_enabled_i, 2) && $past(id_group3_trap_bit_i, 2))));
  endproperty
  a_same_checks: assert property (p_same_checks)
    else $error("second word uses other level checks");

  property p_select;
    req_valid_i |-> ##2 (resp_ff.hit == $past(req_hit, 2));
  endproperty
  a_select: assert property (p_select)
    else $error("encoding match not reflected in answer");

  property p_miss_empty;
    req_valid_i && !req_hit
    |-> ##2 !resp_ff.hit && !resp_ff.trap && (resp_ff.data == '0);
  endproperty
  a_miss_empty: assert property (p_miss_empty)
    else $error("unmapped encoding answered with data");

  property p_reserved_zero;
    (ret_first |-> (resp_ff.data[55:48] == '0) &&
                   (resp_ff.data[19:16] == '0)) and
    (ret_second |-> (resp_ff.data[59:52] == '0));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  property p_first_upper;
    ret_first
    |-> (resp_ff.data[63:60] == `COUNTER_VIRT_CODE) &&
        (resp_ff.data[59:56] == `FINE_TRAP_CODE) &&
        (resp_ff.data[47:44] == `EXCEPTION_SYNC_CODE);
  endproperty
  a_first_upper: assert property (p_first_upper)
    else $error("first word upper fields wrong");

  property p_first_granules;
    ret_first
    |-> (resp_ff.data[43:32] == {3{`STAGE2_GRANULE_CODE}}) &&
        (resp_ff.data[31:28] == `GRANULE_SMALL_CODE) &&
        (resp_ff.data[27:24] == `GRANULE_LARGE_CODE) &&
        (resp_ff.data[23:20] == `GRANULE_MID_CODE);
  endproperty
  a_first_granules: assert property (p_first_granules)
    else $error("first word granule fields wrong");

  property p_first_lower;
    ret_first
    |-> (resp_ff.data[15:12] == `SECURE_SPLIT_CODE) &&
        (resp_ff.data[11:8] == `MIXED_ENDIAN_CODE) &&
        (resp_ff.data[7:4] == `SPACE_ID_WIDTH_CODE) &&
        (resp_ff.data[3:0] == `PHYS_RANGE_CODE);
  endproperty
  a_first_lower: assert property (p_first_lower)
    else $error("first word lower fields wrong");

  property p_second_upper;
    ret_second
    |-> (resp_ff.data[63:60] == `BRANCH_HISTORY_GUARD_CODE) &&
        (resp_ff.data[47:44] == `ALT_FLOAT_CTRL_CODE) &&
        (resp_ff.data[43:40] == `EXT_HYP_CONFIG_CODE) &&
        (resp_ff.data[39:36] == `TRANSLATION_SYNC_CODE) &&
        (resp_ff.data[35:32] == `DELAYED_WAIT_TRAP_CODE);
  endproperty
  a_second_upper: assert property (p_second_upper)
    else $error("second word upper fields wrong");

  property p_second_middle;
    ret_second
    |-> (resp_ff.data[31:28] == `EXEC_NEVER_SPLIT_CODE) &&
        (resp_ff.data[27:24] == `SPEC_ERROR_CODE) &&
        (resp_ff.data[23:20] == `PRIV_ACCESS_NEVER_CODE);
  endproperty
  a_second_middle: assert property (p_second_middle)
    else $error("second word middle fields wrong");

  property p_second_lower;
    ret_second
    |-> (resp_ff.data[19:16] == `ORDERING_REGION_CODE) &&
        (resp_ff.data[15:12] == `HIER_PERM_DISABLE_CODE) &&
        (resp_ff.data[11:8] == `HOST_EXT_CODE) &&
        (resp_ff.data[7:4] == `VM_ID_WIDTH_CODE) &&
        (resp_ff.data[3:0] == `HW_FLAG_UPDATE_CODE);
  endproperty
  a_second_lower: assert property (p_second_lower)
    else $error("second word lower fields wrong");

  property p_write_refused;
    req_valid_i && req_hit && req_i.write
    |-> ##2 resp_ff.undef && !resp_ff.trap && (resp_ff.data == '0);
  endproperty
  a_write_refused: assert property (p_write_refused)
    else $error("write to identification word not refused");

  property p_word_stable;
    ret_first && $past(ret_first) |-> $stable(resp_ff.data);
  endproperty
  a_word_stable: assert property (p_word_stable)
    else $error("first word changed between reads");

  c_low_trap: cover property (
    rd_req && (req_i.current_level == mmfeat_pkg::LEVEL0) ##2 resp_ff.trap);
  c_kernel_hyp: cover property (
    rd_req && (req_i.current_level == mmfeat_pkg::LEVEL1) &&
    el2_enabled_i && id_group3_trap_bit_i ##2 resp_ff.trap);
  c_second_read: cover property (ret_second);
  c_back_to_back: cover property (rd_req ##1 rd_req ##1 ret_first);

endmodule

// [dv/core_req_model.sv]
`timescale 1ns/10ps

module core_req_model (
  input  wire logic                     ref_clk_i,
  input  wire logic                     nrst_i,
  input  wire mmfeat_pkg::sysreg_resp_t resp_i,
  output logic                          req_valid_o,
  output mmfeat_pkg::sysreg_req_t       req_o,
  output logic                          el2_enabled_o,
  output logic                          general_trap_bit_o,
  output logic                          id_group3_trap_bit_o
);
  typedef struct packed {
    mmfeat_pkg::sysreg_req_t req;
    logic [2:0]              ctl;
  } pend_t;

  pend_t                    pend_q[$];
  int                       sent_q[$];
  mmfeat_pkg::sysreg_resp_t got_q[$];
  int                       lat_q[$];
  int                       cyc;
  pend_t                    cur;

  task automatic push(input mmfeat_pkg::sysreg_req_t r,
                      input logic [2:0]              ctl);
    pend_q.push_back({r, ctl});
  endtask

  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
    {el2_enabled_o, general_trap_bit_o, id_group3_trap_bit_o} = 3'h0;
    cyc = 0;
    cur = '0;
  end

  // Idle cycles carry the inverse of the last request, so a design that
  // samples the lines out of turn sees wrong values rather than stale ones.
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (resp_i.valid === 1'b1) begin
      got_q.push_back(resp_i);
      if (sent_q.size() > 0) begin
        lat_q.push_back(cyc - sent_q.pop_front());
      end else begin
        lat_q.push_back(-1);
      end
    end
    #1;
    if (nrst_i && pend_q.size() > 0) begin
      cur = pend_q.pop_front();
      req_valid_o = 1'b1;
      req_o = cur.req;
      {el2_enabled_o, general_trap_bit_o, id_group3_trap_bit_o} = cur.ctl;
      sent_q.push_back(cyc + 1);
    end else begin
      req_valid_o = 1'b0;
      req_o = ~cur.req;
      {el2_enabled_o, general_trap_bit_o, id_group3_trap_bit_o} = ~cur.ctl;
    end
  end
endmodule

// [dv/testbench.sv]
`timescale 1ns/10ps

module testbench;
  localparam logic [63:0] FIRST_WORD = {
    4'h2, 4'h1, 8'h00, 4'h0,
    4'h2, 4'h2, 4'h2,
    4'h0, 4'h0, 4'h1, 4'h0,
    4'h1, 4'h1, 4'h2, 4'h2};
  localparam logic [63:0] SECOND_WORD = {
    4'h1, 8'h00, 4'h1,
    4'h1, 4'h1, 4'h1, 4'h0,
    4'h1, 4'h1, 4'h3,
    4'h1, 4'h2, 4'h1,
    4'h2, 4'h2};
  localparam mmfeat_pkg::exc_level_t LVL1 = mmfeat_pkg::LEVEL1;
  localparam mmfeat_pkg::exc_level_t LVL2 = mmfeat_pkg::LEVEL2;
  localparam mmfeat_pkg::exc_level_t LVL3 = mmfeat_pkg::LEVEL3;

  logic                     ref_clk_i;
  logic                     nrst_i;
  logic                     req_valid_i;
  mmfeat_pkg::sysreg_req_t  req_i;
  logic                     el2_enabled_i;
  logic                     general_trap_bit_i;
  logic                     id_group3_trap_bit_i;
  mmfeat_pkg::sysreg_resp_t resp_o;
  int                       errors;
  int                       compares;
  mmfeat_pkg::sysreg_resp_t exp_q[$];

  memory_model_feature_id_regs DUT (
    .ref_clk_i            (ref_clk_i),
    .nrst_i               (nrst_i),
    .req_valid_i          (req_valid_i),
    .req_i                (req_i),
    .el2_enabled_i        (el2_enabled_i),
    .general_trap_bit_i   (general_trap_bit_i),
    .id_group3_trap_bit_i (id_group3_trap_bit_i),
    .resp_o               (resp_o)
  );

  core_req_model core (
    .ref_clk_i            (ref_clk_i),
    .nrst_i               (nrst_i),
    .resp_i               (resp_o),
    .req_valid_o          (req_valid_i),
    .req_o                (req_i),
    .el2_enabled_o        (el2_enabled_i),
    .general_trap_bit_o   (general_trap_bit_i),
    .id_group3_trap_bit_o (id_group3_trap_bit_i)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  function automatic mmfeat_pkg::sysreg_req_t mk(
    input logic                   wr,
    input logic [1:0]             op0,
    input logic [2:0]             op1,
    input logic [3:0]             crn,
    input logic [3:0]             crm,
    input logic [2:0]             op2,
    input mmfeat_pkg::exc_level_t lvl
  );
    return '{wr, op0, op1, crn, crm, op2, lvl};
  endfunction

  // The control triple is {level 2 enabled, general trap, group-3 trap}.
  function automatic mmfeat_pkg::sysreg_resp_t model(
    input mmfeat_pkg::sysreg_req_t r,
    input logic [2:0]              ctl
  );
    mmfeat_pkg::sysreg_resp_t x;
    x = '0;
    x.valid = 1'b1;
    x.hit = r.op0 == 2'h3 && r.op1 == 3'h0 && r.crn == 4'h0 &&
            r.crm == 4'h7 && r.op2 < 3'h2;
    if (x.hit && r.write) begin
      x.undef = 1'b1;
    end else if (x.hit) begin
      if (r.current_level == mmfeat_pkg::LEVEL0) begin
        x.trap = 1'b1;
        x.trap_level = (ctl[2] && ctl[1]) ? mmfeat_pkg::LEVEL2
                                          : mmfeat_pkg::LEVEL1;
      end else if (r.current_level == mmfeat_pkg::LEVEL1 && ctl[2] &&
                   ctl[0]) begin
        x.trap = 1'b1;
        x.trap_level = mmfeat_pkg::LEVEL2;
      end
      if (x.trap) begin
        x.syndrome = 6'h18;
      end else begin
        x.data = r.op2[0] ? SECOND_WORD : FIRST_WORD;
      end
    end
    return x;
  endfunction

  task automatic check(input string      what,
                       input logic [75:0] exp_v,
                       input logic [75:0] got_v);
    compares++;
    if (got_v !== exp_v) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp_v, got_v);
    end
  endtask

  task automatic send(input mmfeat_pkg::sysreg_req_t r,
                      input logic [2:0]              ctl);
    exp_q.push_back(model(r, ctl));
    core.push(r, ctl);
  endtask

  // Answers are matched in order; extra or missing pulses show in the count.
  task automatic drain(input string name);
    int n;
    n = 0;
    while (core.got_q.size() < exp_q.size() && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    repeat (4) @(posedge ref_clk_i);
    #1;
    check("answer count", 76'(exp_q.size()), 76'(core.got_q.size()));
    while (exp_q.size() > 0 && core.got_q.size() > 0) begin
      check(name, exp_q.pop_front(), core.got_q.pop_front());
      check("latency", 76'(2), 76'(core.lat_q.pop_front()));
    end
    exp_q.delete();
    core.got_q.delete();
    core.lat_q.delete();
    core.sent_q.delete();
    $display("Test %s done", name);
  endtask

  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    $display("ERROR watchdog expected end seen hang");
    finish_test();
  end

  initial begin
    int lvl;
    int ctl;
    int w;
    errors = 0;
    compares = 0;
    nrst_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    check("answer in reset", 76'h0, resp_o);
    repeat (9) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    check("answer after reset", 76'h0, resp_o);
    $display("Test reset done");
    // Two first-word reads in a row let the stability check see a pair.
    send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h7, 3'h0, LVL3), 3'h7);
    send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h7, 3'h0, LVL2), 3'h0);
    send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h7, 3'h1, LVL3), 3'h7);
    drain("values");
    for (lvl = 0; lvl < 4; lvl++) begin
      for (ctl = 0; ctl < 8; ctl++) begin
        for (w = 0; w < 2; w++) begin
          send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h7, 3'(w),
                  mmfeat_pkg::exc_level_t'(lvl[1:0])),
               3'(ctl));
        end
      end
    end
    drain("levels");
    send(mk(1'b0, 2'h2, 3'h0, 4'h0, 4'h7, 3'h0, LVL2), 3'h0);
    send(mk(1'b0, 2'h3, 3'h1, 4'h0, 4'h7, 3'h0, LVL2), 3'h0);
    send(mk(1'b0, 2'h3, 3'h0, 4'h1, 4'h7, 3'h1, LVL2), 3'h0);
    send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h6, 3'h1, LVL2), 3'h0);
    send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h7, 3'h2, LVL2), 3'h0);
    send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h7, 3'h7, LVL2), 3'h0);
    drain("unmapped");
    send(mk(1'b1, 2'h3, 3'h0, 4'h0, 4'h7, 3'h0, LVL2), 3'h0);
    send(mk(1'b1, 2'h3, 3'h0, 4'h0, 4'h7, 3'h1, LVL2), 3'h0);
    send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h7, 3'h0, LVL1), 3'h6);
    send(mk(1'b0, 2'h3, 3'h0, 4'h0, 4'h7, 3'h1, LVL1), 3'h6);
    drain("writes");
    finish_test();
  end
endmodule
